// >>> bcp_pkg.sv
/*
 * Shared constants and types for the balancer chain command port: command byte layout,
 * balance word layout, check-code polynomial, reset values and link timing.
 * Assumes both ends run on one 20 MHz reference clock and the link clock is sampled.
 */
// Behaviour
// [RQ1] frames run while select low, command byte first
// [RQ2] top five bits must equal chain address
// [RQ3] bits six, seven choose store/readback/status/execute
// [RQ4] host makes command byte parity even
// [RQ5] bad parity stops balancing, ignores frame
// [RQ6] store data must be whole sixteen-bit words
// [RQ7] discarded store clears pending, execute then idles
// [RQ8] first word reaches top device, msb first
// [RQ9] word: six two-bit fields then check code
// [RQ10] field: idle, nonsync, sync discharge, charge
// [RQ11] sync discharge primary first, charge secondary first
// [RQ12] nonsync: no secondary drive, wait volt-second timer
// [RQ13] single transformer rejects multi-balancer commands
// [RQ14] crc4 x^4+x+1 over sixteen bits, zero valid
// [RQ15] host sends check bits inverted
// [RQ16] bad check clears pending, execute then idles
// [RQ17] readback returns latched message plus inverted crc
// [RQ18] status word twelve bits plus inverted crc
// [RQ19] gate drive ok only for executed balancers
// [RQ20] fault-free bits only after active execute
// [RQ21] status bits ten to twelve read zero
// [RQ22] pending command resets to 0x000F
// [RQ23] execute runs last good command, ignores data
// [RQ24] chain forms one long shift register; data_to_host carries only this device's own reply, never the shifted-in bits
package bcp_pkg;
	localparam logic [4:0]  CHAIN_ADDR      = 5'h15;
	localparam int          CMD_BITS        = 8;
	localparam int          WORD_BITS       = 16;
	localparam int          MSG_BITS        = 12;
	localparam int          CRC_BITS        = 4;
	localparam int          NUM_BAL         = 6;
	localparam logic [15:0] PENDING_RESET   = 16'h000F;
	localparam logic [3:0]  CRC_POLY_LOW    = 4'h3;
	localparam logic [3:0]  CRC_INVERT      = 4'hF;
	localparam logic [1:0]  OP_STORE        = 2'h0;
	localparam logic [1:0]  OP_READBACK     = 2'h1;
	localparam logic [1:0]  OP_STATUS       = 2'h2;
	localparam logic [1:0]  OP_EXECUTE      = 2'h3;
	localparam logic [1:0]  BAL_IDLE        = 2'h0;
	localparam logic [1:0]  BAL_NONSYNC     = 2'h1;
	localparam logic [1:0]  BAL_SYNC        = 2'h2;
	localparam logic [1:0]  BAL_CHARGE      = 2'h3;
	localparam int          CLK_HZ          = 20_000_000;
	localparam int          LINK_HALF_NS    = 200;
	localparam int          LINK_HALF_CYC   = (LINK_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int          CS_SETUP_CYC    = LINK_HALF_CYC;

	typedef enum logic [1:0] {
		BCP_PH_IDLE,
		BCP_PH_PRI,
		BCP_PH_SEC,
		BCP_PH_WAIT
	} bcp_phase_t;

	// crc4 over n msb-first bits, remainder only
	function automatic logic [3:0] bcp_crc4(input logic [15:0] data, input int nbits);
		logic [3:0] r;
		logic       fb;
		r = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (i < nbits) begin
				fb = r[3] ^ data[i];
				r  = {r[2:0], 1'b0} ^ (fb ? CRC_POLY_LOW : 4'h0);
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] bcp_seal(input logic [11:0] msg);
		return {msg, bcp_crc4({4'h0, msg}, MSG_BITS) ^ CRC_INVERT};
	endfunction
endpackage

// >>> bcp_link_if.sv
/*
 * Serial link between host and one device end: select, clock, data each way.
 * Assumes the bench joins further devices itself for a longer chain.
 */
`timescale 1ns/1ps
interface bcp_link_if;
	logic chain_select_in_n;
	logic serial_clock_in;
	logic data_to_dev;
	logic data_to_host;

	modport host (
		output chain_select_in_n,
		output serial_clock_in,
		output data_to_dev,
		input  data_to_host
	);
	modport dev (
		input  chain_select_in_n,
		input  serial_clock_in,
		input  data_to_dev,
		output data_to_host
	);
endinterface

// >>> bcp_device.sv
/*
 * Device end: samples the link, decodes the command byte, stores/reads/executes
 * balance words, and steps a simple per-balancer phase model.
 * Assumes link pins are asynchronous to i_ref_clk and analog comparators arrive as levels.
 */
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module bcp_device
	import bcp_pkg::*;
(
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_nrst,
	bcp_link_if.dev                   link,
	input  wire logic                 i_single_xfmr,
	input  wire logic [NUM_BAL-1:0]   i_peak_hit,
	input  wire logic [NUM_BAL-1:0]   i_zero_hit,
	input  wire logic [NUM_BAL-1:0]   i_volt_sec_done,
	input  wire logic [NUM_BAL-1:0]   i_gate_ok,
	input  wire logic                 i_cells_ok,
	input  wire logic                 i_sec_ok,
	input  wire logic                 i_temp_ok,
	output logic      [NUM_BAL-1:0]   o_pri_gate,
	output logic      [NUM_BAL-1:0]   o_sec_gate,
	output logic      [NUM_BAL-1:0]   o_zero_sense_en,
	output logic      [15:0]          o_pending,
	output logic      [11:0]          o_running
);
	logic [1:0]  cs_sync_ff, sck_sync_ff, sdi_sync_ff;
	logic        sck_prev_ff;
	logic [7:0]  cmd_ff;
	logic [4:0]  bit_cnt_ff;
	logic        cmd_done_ff;
	logic        ignore_ff;
	logic [1:0]  op_ff;
	logic [15:0] shift_ff;
	logic        words_ok_ff;
	logic [15:0] pending_ff;
	logic [11:0] running_ff;
	logic [15:0] out_ff;
	logic        sdo_ff;
	logic        executed_ff;
	bcp_phase_t  phase_ff [NUM_BAL];

	// comparator and strap levels come from the power stage, off this clock
	typedef struct packed {
		logic               single_xfmr;
		logic [NUM_BAL-1:0] peak_hit;
		logic [NUM_BAL-1:0] zero_hit;
		logic [NUM_BAL-1:0] volt_sec_done;
		logic [NUM_BAL-1:0] gate_ok;
		logic               cells_ok;
		logic               sec_ok;
		logic               temp_ok;
	} bcp_levels_t;
	bcp_levels_t        lvl_s1_ff, lvl_s2_ff;
	logic [NUM_BAL-1:0] act_mask;
	logic [NUM_BAL-1:0] gate_ok_msb;

	wire cs_n   = cs_sync_ff[1];
	wire sck    = sck_sync_ff[1];
	wire sdi    = sdi_sync_ff[1];
	wire rise   = sck & ~sck_prev_ff & ~cs_n;
	wire fall   = ~sck & sck_prev_ff & ~cs_n;
	wire [7:0]  nxt_cmd   = {cmd_ff[6:0], sdi};
	wire [15:0] nxt_shift = {shift_ff[14:0], sdi};

	function automatic logic multi_active(input logic [11:0] m);
		int n;
		n = 0;
		for (int i = 0; i < NUM_BAL; i++) begin
			if (m[2*i +: 2] != BAL_IDLE)
				n++;
		end
		return n > 1;
	endfunction

	// check bits travel inverted, so an all-zero word never passes
	wire store_good = (bcp_crc4({nxt_shift[15:4], nxt_shift[3:0] ^ CRC_INVERT}, WORD_BITS) == 4'h0) //RQ14
		&& !(lvl_s2_ff.single_xfmr && multi_active(nxt_shift[15:4])); //RQ13

	// only the second stage feeds logic
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			cs_sync_ff  <= 2'b11;
			sck_sync_ff <= 2'b00;
			sdi_sync_ff <= 2'b00;
			sck_prev_ff <= 1'b0;
			lvl_s1_ff   <= '0;
			lvl_s2_ff   <= '0;
		end else begin
			cs_sync_ff  <= {cs_sync_ff[0], link.chain_select_in_n};
			sck_sync_ff <= {sck_sync_ff[0], link.serial_clock_in};
			sdi_sync_ff <= {sdi_sync_ff[0], link.data_to_dev};
			sck_prev_ff <= sck;
			lvl_s1_ff   <= {i_single_xfmr, i_peak_hit, i_zero_hit, i_volt_sec_done,
				i_gate_ok, i_cells_ok, i_sec_ok, i_temp_ok};
			lvl_s2_ff   <= lvl_s1_ff;
		end
	end

	// frame decoding and pending register
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			cmd_ff      <= 8'h00;
			bit_cnt_ff  <= 5'd0;
			cmd_done_ff <= 1'b0;
			ignore_ff   <= 1'b0;
			op_ff       <= OP_STORE;
			shift_ff    <= 16'h0000;
			words_ok_ff <= 1'b1;
			pending_ff  <= PENDING_RESET; //RQ22
			running_ff  <= 12'h000;
			executed_ff <= 1'b0;
		end else if (cs_n) begin //RQ1
			// a store ending mid-word is discarded at frame end
			if (cmd_done_ff && !ignore_ff && op_ff == OP_STORE && (bit_cnt_ff != 5'd0 || !words_ok_ff))
				pending_ff <= 16'h0000; //RQ6 RQ7
			cmd_done_ff <= 1'b0;
			ignore_ff   <= 1'b0; //RQ2
			bit_cnt_ff  <= 5'd0;
			words_ok_ff <= 1'b1;
		end else if (rise && !cmd_done_ff) begin
			cmd_ff     <= nxt_cmd;
			bit_cnt_ff <= bit_cnt_ff + 5'd1;
			if (bit_cnt_ff == 5'(CMD_BITS - 1)) begin
				cmd_done_ff <= 1'b1;
				bit_cnt_ff  <= 5'd0;
				op_ff       <= nxt_cmd[2:1]; //RQ3
				shift_ff    <= (nxt_cmd[2:1] == OP_READBACK) ? bcp_seal(pending_ff[15:4]) : 16'h0000;
				if (^nxt_cmd) begin
					ignore_ff  <= 1'b1; //RQ5
					running_ff <= 12'h000; //RQ5
				end else if (nxt_cmd[7:3] != CHAIN_ADDR) begin
					ignore_ff <= 1'b1; //RQ2
				end else if (nxt_cmd[2:1] == OP_EXECUTE) begin
					running_ff  <= pending_ff[15:4]; //RQ23 RQ7 RQ16
					executed_ff <= 1'b1;
					ignore_ff   <= 1'b1; //RQ23
				end
			end
		end else if (rise && !ignore_ff) begin
			shift_ff   <= nxt_shift; //RQ24
			bit_cnt_ff <= (bit_cnt_ff == 5'(WORD_BITS - 1)) ? 5'd0 : bit_cnt_ff + 5'd1;
			if (op_ff == OP_STORE && bit_cnt_ff == 5'(WORD_BITS - 1)) begin
				// last full word held when select rises is ours
				pending_ff  <= store_good ? nxt_shift : 16'h0000; //RQ8 RQ16
				words_ok_ff <= store_good;
			end
		end
	end

	// vectors index balancer one at bit 0, the status word lists it first
	always_comb begin
		for (int i = 0; i < NUM_BAL; i++) begin
			act_mask[i]              = running_ff[11-2*i -: 2] != BAL_IDLE;
			gate_ok_msb[NUM_BAL-1-i] = lvl_s2_ff.gate_ok[i] && act_mask[i]; //RQ19
		end
	end
	wire [11:0] status_msg = {gate_ok_msb, {3{executed_ff && running_ff != 12'h000}} & //RQ19 RQ20
		{lvl_s2_ff.cells_ok, lvl_s2_ff.sec_ok, lvl_s2_ff.temp_ok}, 3'b000}; //RQ21

	// output shift: own word first, then idle-high ones shifted in behind it
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			out_ff <= 16'h0000;
			sdo_ff <= 1'b1;
		end else if (cs_n) begin
			sdo_ff <= 1'b1;
		end else if (rise && bit_cnt_ff == 5'(CMD_BITS - 1) && !cmd_done_ff) begin
			out_ff <= (nxt_cmd[2:1] == OP_STATUS) ? bcp_seal(status_msg) : bcp_seal(pending_ff[15:4]); //RQ17 RQ18
		end else if (fall && cmd_done_ff && !ignore_ff && op_ff != OP_STORE) begin
			sdo_ff <= out_ff[15];
			out_ff <= {out_ff[14:0], 1'b1};
		end
	end
	assign link.data_to_host = sdo_ff;

	// per-balancer power phase model
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			for (int i = 0; i < NUM_BAL; i++)
				phase_ff[i] <= BCP_PH_IDLE;
		end else begin
			for (int i = 0; i < NUM_BAL; i++) begin
				unique case (phase_ff[i])
					BCP_PH_IDLE: if (act_mask[i]) phase_ff[i] <= BCP_PH_PRI;
					BCP_PH_PRI: begin
						if (!act_mask[i])
							phase_ff[i] <= BCP_PH_IDLE;
						else if (lvl_s2_ff.peak_hit[i])
							phase_ff[i] <= (running_ff[11-2*i -: 2] == BAL_NONSYNC) ? BCP_PH_WAIT : BCP_PH_SEC;
					end
					BCP_PH_SEC: if (!act_mask[i] || lvl_s2_ff.zero_hit[i]) phase_ff[i] <= BCP_PH_PRI; //RQ11
					BCP_PH_WAIT: if (!act_mask[i] || lvl_s2_ff.volt_sec_done[i]) phase_ff[i] <= BCP_PH_PRI; //RQ12
				endcase
			end
		end
	end

	// first phase drives the switch that ramps to peak
	always_comb begin
		for (int i = 0; i < NUM_BAL; i++) begin
			logic [1:0] f;
			f = running_ff[11-2*i -: 2]; //RQ9 RQ10
			o_pri_gate[i] = (f == BAL_CHARGE) ? phase_ff[i] == BCP_PH_SEC : phase_ff[i] == BCP_PH_PRI && act_mask[i]; //RQ11
			o_sec_gate[i] = (f == BAL_CHARGE) ? phase_ff[i] == BCP_PH_PRI && act_mask[i]
				: (f == BAL_SYNC) && phase_ff[i] == BCP_PH_SEC; //RQ12
			o_zero_sense_en[i] = act_mask[i] && f != BAL_NONSYNC; //RQ12
		end
	end

	assign o_pending = pending_ff;
	assign o_running = running_ff;
endmodule

// >>> bcp_host.sv
/*
 * Host end: generates select and a divided serial clock, sends a command byte
 * then at most one word, and collects the returned word. Software drives it through a plain port.
 * Assumes a single device word per transfer is enough for most frames; longer frames are not supported.
 */
`timescale 1ns/1ps
module bcp_host
	import bcp_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_nrst,
	bcp_link_if.host         link,
	input  wire logic [1:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata
);
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_DATA = 2'h1;
	localparam logic [1:0] REG_STAT = 2'h2;

	typedef enum logic [1:0] { BCP_H_IDLE, BCP_H_SETUP, BCP_H_SHIFT, BCP_H_END } bcp_hstate_t;

	bcp_hstate_t state_ff;
	logic [7:0]  div_ff;
	logic        sck_ff, cs_n_ff, mosi_ff;
	logic [1:0]  op_ff;
	logic        bad_par_ff;
	logic [15:0] tx_ff, rx_ff, rx_last_ff;
	logic [5:0]  bits_left_ff;
	logic [4:0]  word_bit_ff;
	logic        cmd_phase_ff;
	logic [1:0]  miso_sync_ff;
	logic        done_ff;
	logic [15:0] rdata_ff;

	wire tick = div_ff == 8'(LINK_HALF_CYC - 1);
	wire [7:0] cmd_byte = {CHAIN_ADDR, op_ff, ^{CHAIN_ADDR, op_ff} ^ bad_par_ff}; //RQ4
	wire busy = state_ff != BCP_H_IDLE;

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst)
			miso_sync_ff <= 2'b11;
		else
			miso_sync_ff <= {miso_sync_ff[0], link.data_to_host};
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst)
			div_ff <= 8'd0;
		else
			div_ff <= (tick || !busy) ? 8'd0 : div_ff + 8'd1;
	end

	// ctrl write: [1:0] op, [2] flip parity, [3] send one data word
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			state_ff     <= BCP_H_IDLE;
			sck_ff       <= 1'b0;
			cs_n_ff      <= 1'b1;
			mosi_ff      <= 1'b0;
			op_ff        <= OP_STORE;
			bad_par_ff   <= 1'b0;
			tx_ff        <= 16'h0000;
			rx_ff        <= 16'h0000;
			rx_last_ff   <= 16'h0000;
			bits_left_ff <= 6'd0;
			word_bit_ff  <= 5'd0;
			cmd_phase_ff <= 1'b0;
			done_ff      <= 1'b0;
		end else begin
			if (i_wr && !busy && i_addr == REG_DATA)
				tx_ff <= i_wdata; //RQ15
			unique case (state_ff)
				BCP_H_IDLE: if (i_wr && i_addr == REG_CTRL) begin
					op_ff        <= i_wdata[1:0];
					bad_par_ff   <= i_wdata[2];
					bits_left_ff <= 6'(CMD_BITS + (i_wdata[3] ? WORD_BITS : 0)); //RQ6
					cs_n_ff      <= 1'b0; //RQ1
					cmd_phase_ff <= 1'b1;
					word_bit_ff  <= 5'd0;
					done_ff      <= 1'b0;
					state_ff     <= BCP_H_SETUP;
				end
				BCP_H_SETUP: if (tick) begin
					mosi_ff  <= cmd_byte[7];
					state_ff <= BCP_H_SHIFT;
				end
				BCP_H_SHIFT: if (tick) begin
					sck_ff <= ~sck_ff;
					if (!sck_ff) begin
						bits_left_ff <= bits_left_ff - 6'd1;
						word_bit_ff  <= word_bit_ff + 5'd1;
					end else begin
						// two synchronisers each way put the reply past the rising edge
						rx_ff <= {rx_ff[14:0], miso_sync_ff[1]};
						if (bits_left_ff == 6'd0) begin
							state_ff <= BCP_H_END;
						end else if (cmd_phase_ff && word_bit_ff == 5'(CMD_BITS)) begin
							cmd_phase_ff <= 1'b0;
							word_bit_ff  <= 5'd0;
							mosi_ff      <= tx_ff[15]; //RQ8
							tx_ff        <= {tx_ff[14:0], 1'b0};
						end else if (cmd_phase_ff) begin
							mosi_ff <= cmd_byte[3'(CMD_BITS - 1) - word_bit_ff[2:0]];
						end else begin
							mosi_ff <= tx_ff[15];
							tx_ff   <= {tx_ff[14:0], 1'b0};
						end
					end
				end
				BCP_H_END: if (tick) begin
					cs_n_ff    <= 1'b1;
					rx_last_ff <= rx_ff;
					done_ff    <= 1'b1;
					state_ff   <= BCP_H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst)
			rdata_ff <= 16'h0000;
		else if (i_rd)
			unique case (i_addr)
				REG_DATA: rdata_ff <= rx_last_ff;
				REG_STAT: rdata_ff <= {14'h0000, done_ff, busy};
				default:  rdata_ff <= {14'h0000, bad_par_ff, 1'b0};
			endcase
	end

	assign o_rdata                = rdata_ff;
	assign link.chain_select_in_n = cs_n_ff;
	assign link.serial_clock_in   = sck_ff;
	assign link.data_to_dev       = mosi_ff;
endmodule

// >>> bcp_link_properties.sv
/*
 * Wire checker for the balancer chain link: select framing, clock shape, data
 * stability, command address and whole-word frames.
 * Assumes one reference clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module bcp_link_properties
	import bcp_pkg::*;
(
	input  wire logic i_ref_clk,
	input  wire logic i_nrst,
	input  wire logic chain_select_in_n,
	input  wire logic serial_clock_in,
	input  wire logic data_to_dev,
	input  wire logic data_to_host
);
	logic       sck_d_ff;
	logic [4:0] nbit_ff;
	logic [7:0] cmd_ff;
	wire        sck_rise = serial_clock_in & ~sck_d_ff;

	always_ff @(posedge i_ref_clk) begin
		sck_d_ff <= serial_clock_in;
	end
	// saturating count, frames seen here are 8 or 24 bits long
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst || chain_select_in_n) begin
			nbit_ff <= 5'h0;
		end else if (sck_rise && nbit_ff != 5'h1F) begin
			nbit_ff <= nbit_ff + 5'h1;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			cmd_ff <= 8'h00;
		end else if (sck_rise && !chain_select_in_n && nbit_ff < 5'h8) begin
			cmd_ff <= {cmd_ff[6:0], data_to_dev};
		end
	end

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);

	a_idle_clock_low: assert property (chain_select_in_n && $past(chain_select_in_n) |-> !serial_clock_in)
		else $error("link clock moved outside a frame");
	a_clock_in_frame: assert property (sck_rise |-> !chain_select_in_n)
		else $error("link clock rose with select high");
	a_select_setup: assert property ($fell(chain_select_in_n) |-> !serial_clock_in [*4])
		else $error("link clock rose too soon after select fell");
	a_clock_high_time: assert property ($rose(serial_clock_in) |-> serial_clock_in [*4] ##1 !serial_clock_in)
		else $error("link clock high time wrong");
	a_mosi_steady: assert property (!chain_select_in_n && serial_clock_in |-> $stable(data_to_dev))
		else $error("host data changed while clock high");
	a_miso_steady: assert property (!chain_select_in_n && serial_clock_in && $past(serial_clock_in)
		|-> $stable(data_to_host))
		else $error("device data changed while clock high");
	a_miso_idle: assert property (chain_select_in_n [*6] |-> data_to_host)
		else $error("device data not idle high");
	a_chain_address: assert property ($changed(nbit_ff) && nbit_ff == 5'h8 |-> cmd_ff[7:3] == CHAIN_ADDR)
		else $error("command byte address wrong");
	a_whole_words: assert property ($rose(chain_select_in_n) |-> nbit_ff == 5'h8 || nbit_ff == 5'h18)
		else $error("frame not command byte plus whole words");

	c_word_frame: cover property ($rose(chain_select_in_n) && nbit_ff == 5'h18);
	c_byte_frame: cover property ($rose(chain_select_in_n) && nbit_ff == 5'h8);
	c_reply_bit: cover property (!chain_select_in_n && $fell(data_to_host));
endmodule

// >>> test_balancer_chain_command_port.sv
/*
 * Self-checking bench: host and device ends joined by the link, driven through
 * the host register port. Assumes host regs ctrl 0, data 1, stat 2.
 */
`timescale 1ns/1ps
module test_balancer_chain_command_port
	import bcp_pkg::*;
;
	logic        i_ref_clk = 1'b0;
	logic        i_nrst    = 1'b0;
	logic [1:0]  addr      = 2'h0;
	logic [15:0] wdata     = 16'h0000;
	logic        wr        = 1'b0;
	logic        rd        = 1'b0;
	logic        xfmr      = 1'b0;
	logic [5:0]  peak      = 6'h00;
	logic [5:0]  zero      = 6'h00;
	logic [5:0]  vsec      = 6'h00;
	logic [5:0]  gok       = 6'h3F;
	logic        cok       = 1'b1;
	logic        sok       = 1'b1;
	logic        tok       = 1'b1;
	logic [15:0] rdata;
	logic [5:0]  pri;
	logic [5:0]  sec;
	logic [5:0]  zen;
	logic [15:0] pend;
	logic [11:0] run;
	int          n_errors     = 0;
	int          total_checks = 0;
	int          cyc          = 0;

	bcp_link_if link ();
	bcp_host u_bcp_host (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .link(link), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata));
	bcp_device u_bcp_device (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .link(link), .i_single_xfmr(xfmr),
		.i_peak_hit(peak), .i_zero_hit(zero), .i_volt_sec_done(vsec), .i_gate_ok(gok), .i_cells_ok(cok),
		.i_sec_ok(sok), .i_temp_ok(tok), .o_pri_gate(pri), .o_sec_gate(sec), .o_zero_sense_en(zen),
		.o_pending(pend), .o_running(run));
	bcp_link_properties u_props (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .chain_select_in_n(link.chain_select_in_n),
		.serial_clock_in(link.serial_clock_in), .data_to_dev(link.data_to_dev), .data_to_host(link.data_to_host));

	initial begin
		forever #25 i_ref_clk = ~i_ref_clk;
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// independent crc: message times x^4 mod x^4+x+1, check bits sent inverted
	function automatic logic [15:0] seal(input logic [11:0] m);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 11; i >= 0; i--) begin
			r = {r[2:0], 1'b0} ^ ((r[3] ^ m[i]) ? 4'h3 : 4'h0);
		end
		return {m, ~r};
	endfunction

	// extra edge after each strobe so no strobe is assigned twice in one step
	task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_ref_clk);
		wr <= 1'b0;
		@(posedge i_ref_clk);
	endtask

	task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge i_ref_clk);
	endtask

	// ctl: bit3 append word, bit2 flip parity, bits1:0 op
	task automatic frame(input logic [3:0] ctl, input logic [15:0] d, output logic [15:0] got);
		logic [15:0] s;
		bus_wr(2'h1, d);
		bus_wr(2'h0, {12'h000, ctl});
		s = 16'h0001;
		while (s[1:0] !== 2'b10) begin
			bus_rd(2'h2, s);
		end
		bus_rd(2'h1, got);
	endtask

	task automatic gchk(input logic [6:0] exp);
		repeat (4) @(posedge i_ref_clk);
		#1 chk("gates", {9'h000, exp}, {9'h000, pri[2:0], sec[2:0], zen[1]});
		@(posedge i_ref_clk);
	endtask

	initial begin
		logic [15:0] w;
		logic [11:0] m;
		m = 12'h9C0;
		repeat (8) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		@(posedge i_ref_clk);
		chk("pending", 16'h000F, pend);
		frame(4'h9, 16'h0000, w);
		chk("readback", 16'h000F, w);
		frame(4'hA, 16'h0000, w);
		chk("status", 16'h000F, w);
		frame(4'h8, seal(m), w);
		chk("pending", seal(m), pend);
		chk("running", 16'h0000, {4'h0, run});
		frame(4'h9, 16'h0000, w);
		chk("readback", seal(m), w);
		frame(4'h3, 16'h0000, w);
		chk("running", {4'h0, m}, {4'h0, run});
		gchk(7'b011_100_0);
		peak <= 6'h07;
		gchk(7'b100_001_0);
		peak <= 6'h00;
		vsec <= 6'h02;
		gchk(7'b110_001_0);
		gok <= 6'h05;
		tok <= 1'b0;
		frame(4'hA, 16'h0000, w);
		chk("status", seal(12'hA30), w);
		frame(4'h8, seal(12'h200) ^ 16'h0001, w);
		chk("running", {4'h0, m}, {4'h0, run});
		frame(4'h9, 16'h0000, w);
		chk("readback", 16'h000F, w);
		frame(4'h3, 16'h0000, w);
		chk("running", 16'h0000, {4'h0, run});
		frame(4'h8, seal(m), w);
		frame(4'h3, 16'h0000, w);
		frame(4'h7, 16'h0000, w);
		chk("running", 16'h0000, {4'h0, run});
		frame(4'hC, seal(12'h800), w);
		chk("pending", seal(m), pend);
		frame(4'h3, 16'h0000, w);
		chk("running", {4'h0, m}, {4'h0, run});
		xfmr <= 1'b1;
		frame(4'h8, seal(m), w);
		frame(4'h3, 16'h0000, w);
		chk("running", 16'h0000, {4'h0, run});
		frame(4'h8, seal(12'h800), w);
		frame(4'h3, 16'h0000, w);
		chk("running", 16'h0800, {4'h0, run});
		stop_test();
	end
endmodule
